// >>> irf_cfg.svh
`ifndef IRF_CFG_SVH
`define IRF_CFG_SVH
// ==========================================================
// register offsets
`define IRF_OFS_ROUTE 8'h2E
`define IRF_OFS_FCTRL 8'h30
`define IRF_OFS_THRLO 8'h31
`define IRF_OFS_STAT 8'h38
`define IRF_OFS_MASK 8'h39
`define IRF_OFS_LVLLO 8'h3A
`define IRF_OFS_LVLHI 8'h3B
// ==========================================================
// reset values
`define IRF_RST_ROUTE 8'h80
`define IRF_RST_FCTRL 8'h00
`define IRF_RST_THRLO 8'h00
`define IRF_RST_STAT 3'h0
`define IRF_RST_MASK 3'h0
// ==========================================================
// routing field positions
`define IRF_B_NVM_COMPLETE_STATUS 7
`define IRF_B_NVM_REQ 6
`define IRF_B_UV 5
`define IRF_B_OVR 4
`define IRF_B_PAR 3
`define IRF_B_TAP3 2
`define IRF_B_TAP2 1
`define IRF_B_TAP1 0
// ==========================================================
// fifo control field positions
`define IRF_B_PTR_RST 7
`define IRF_B_CH_TAG 6
`define IRF_B_MODE_HI 5
`define IRF_B_MODE_LO 4
`define IRF_B_EXT_TRIG 3
`define IRF_B_THR_MSB 0
// ==========================================================
// event status positions
`define IRF_S_WMARK 0
`define IRF_S_OVRUN 1
`define IRF_S_TRIG 2
// ==========================================================
// fifo geometry
`define IRF_DEPTH 320
`define IRF_LAST 9'h13F
`endif

// >>> irf_pkg.sv
package irf_pkg;
  // ==========================================================
  // fifo operating modes
  typedef enum logic [1:0] {
    IRF_MODE_OFF = 2'b00,
    IRF_MODE_NORMAL = 2'b01,
    IRF_MODE_STREAM = 2'b10,
    IRF_MODE_TRIGGER = 2'b11
  } irf_mode_t;
  // trigger capture states, gray along idle, armed, hold
  typedef enum logic [1:0] {
    IRF_TRG_IDLE = 2'b00,
    IRF_TRG_ARMED = 2'b01,
    IRF_TRG_HOLD = 2'b11
  } irf_trg_t;
  typedef logic [8:0] irf_ptr_t;
  typedef logic [17:0] irf_word_t;
endpackage

// >>> irf_top.sv
`timescale 1ns/1ps
`include "irf_cfg.svh"
module irf_top
  import irf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // status sources for pin b
  input wire logic nvm_complete_status_in,
  input wire logic nvm_request_status_in,
  input wire logic undervoltage_held_flag_in,
  input wire logic overrange_held_flag_in,
  input wire logic parity_fault_status_in,
  input wire logic tap_three_in,
  input wire logic tap_two_in,
  input wire logic tap_one_in,
  // sample stream in
  input wire logic sample_valid_in,
  input wire logic [15:0] sample_data_in,
  input wire logic [1:0] sample_chan_in,
  input wire logic pulse_density_output_in,
  input wire logic frame_sync_pin_in,
  input wire logic activity_in,
  // sample read port
  input wire logic pop_in,
  output logic pop_valid_out,
  output logic [17:0] pop_data_out,
  // interrupts
  output logic irq_pin_b_out,
  output logic irq_out
);

  // ==========================================================
  // behaviour notes
  // storage is 320 entries of 18 bits held in flip-flops.
  // pointers wrap from the last entry back to zero.
  // a 10 bit level counter tells a full fifo from an empty one.
  // equal pointers cannot, since both cases share them.
  // a full fifo reads 0x140 through the two level registers.
  // normal mode refuses a sample when full and flags overrun.
  // a held trigger capture refuses in the same way.
  // stream mode and an armed trigger drop the oldest entry.
  // a push and a pop in one cycle leave the level unchanged.
  // on a full fifo that pop frees the slot the push takes.
  // the pop reads the old entry, the push lands after the edge.
  // pops on an empty fifo are ignored and raise no valid.
  // pop data hold their value until the next accepted pop.
  // mode off takes no samples and keeps what is stored.
  // pulse density output acts as mode off.
  // pointer reset holds the fifo empty while its bit is one.
  // pops are ignored while pointer reset is held.
  // software writes the bit back to zero to resume.
  // the channel tag is chosen by the tag bit at write time.
  // untagged entries carry zeros in the two tag bits.
  // reserved control bits 2 and 1 always read zero.
  // watermark re-sets on every cycle the level meets the threshold.
  // a zero threshold keeps the watermark set at all times.
  // reading status returns the value from before the clear.
  // overrun and trigger bits clear by writing a one.
  // a hardware set in the clear cycle wins, so no event is lost.
  // the frame sync detector rests low, as the idle pin does.
  // a pin already high at reset release counts as one edge.
  // internal activity is a level, sampled every cycle.
  // leaving trigger mode drops the capture back to idle.
  // pin b lags its sources by one clock and cannot glitch.
  // read data stand one cycle after the strobe, zero otherwise.
  // unmapped offsets read zero and ignore writes.

  // ==========================================================
  // helpers
  function automatic irf_ptr_t ptr_inc(input irf_ptr_t p);
    ptr_inc = (p == `IRF_LAST) ? 9'h000 : p + 9'h001;
  endfunction

  // sticky status bit after a write, a one clears it
  function automatic logic w1c(input logic held, input logic wr_bit);
    w1c = held & ~wr_bit;
  endfunction

  // a sample fits when room is left or a pop frees a slot
  function automatic logic has_room(input logic is_full, input logic popping);
    has_room = !is_full || popping;
  endfunction

  // the oldest entry goes when full and nothing is popped
  function automatic logic must_drop(input logic is_full, input logic popping);
    must_drop = is_full && !popping;
  endfunction

  // ==========================================================
  // state
  // configuration registers
  logic [7:0] route_q, route_d;
  logic [7:0] fctrl_q, fctrl_d;
  logic [7:0] thrlo_q, thrlo_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  // readback and interrupt outputs
  logic [7:0] rdata_q, rdata_d;
  logic pin_q, pin_d;
  logic irq_q, irq_d;
  // fifo pointers, level and trigger capture
  irf_ptr_t rptr_q, rptr_d;
  irf_ptr_t wptr_q, wptr_d;
  logic [9:0] level_q, level_d;
  irf_trg_t trg_q, trg_d;
  logic frame_sync_pin_q;
  // read port and storage
  logic pop_valid_q, pop_valid_d;
  irf_word_t pop_data_q, pop_data_d;
  irf_word_t mem_q [`IRF_DEPTH];

  // ==========================================================
  // decoded controls
  irf_mode_t mode;
  logic ptr_rst;
  logic trig_evt;
  logic full;
  logic empty;
  logic push_ok;
  logic do_pop;
  logic drop_old;
  logic overrun;
  logic wmark_hit;
  logic stat_rd;
  irf_word_t wr_word;
  logic [8:0] thresh;

  // mode decode with pulse density override
  always_comb begin
    mode = irf_mode_t'(fctrl_q[`IRF_B_MODE_HI:`IRF_B_MODE_LO]);
    if (pulse_density_output_in) begin
      mode = IRF_MODE_OFF;
    end
  end

  // fifo datapath decisions
  always_comb begin
    ptr_rst = fctrl_q[`IRF_B_PTR_RST];
    full = (level_q == 10'(`IRF_DEPTH));
    empty = (level_q == 10'h000);
    // trigger source, only looked at in trigger mode
    trig_evt = (mode == IRF_MODE_TRIGGER) &&
      (fctrl_q[`IRF_B_EXT_TRIG] ? (frame_sync_pin_in && !frame_sync_pin_q) : activity_in);
    do_pop = pop_in && !empty && !ptr_rst;
    push_ok = 1'b0;
    drop_old = 1'b0;
    overrun = 1'b0;
    if (sample_valid_in && !ptr_rst) begin
      unique case (mode)
        IRF_MODE_OFF: push_ok = 1'b0;
        IRF_MODE_NORMAL: begin
          push_ok = has_room(full, do_pop);
          overrun = !push_ok;
        end
        IRF_MODE_STREAM: begin
          push_ok = 1'b1;
          drop_old = must_drop(full, do_pop);
        end
        IRF_MODE_TRIGGER: begin
          if (trg_q == IRF_TRG_HOLD) begin
            push_ok = has_room(full, do_pop);
            overrun = !push_ok;
          end else begin
            push_ok = 1'b1;
            drop_old = must_drop(full, do_pop);
          end
        end
      endcase
    end
    // tag above the sample or plain signed sample
    if (fctrl_q[`IRF_B_CH_TAG]) begin
      wr_word = {sample_chan_in, sample_data_in};
    end else begin
      wr_word = {2'b00, sample_data_in};
    end
  end

  // pointers, level, trigger state and read port
  always_comb begin
    rptr_d = rptr_q;
    wptr_d = wptr_q;
    level_d = level_q;
    trg_d = trg_q;
    pop_valid_d = do_pop;
    pop_data_d = pop_data_q;
    if (do_pop) begin
      pop_data_d = mem_q[rptr_q];
      rptr_d = ptr_inc(rptr_q);
    end
    if (push_ok) begin
      wptr_d = ptr_inc(wptr_q);
    end
    if (drop_old) begin
      rptr_d = ptr_inc(rptr_q);
    end
    if (push_ok && !do_pop && !drop_old) begin
      level_d = level_q + 10'h001;
    end else if (do_pop && !push_ok) begin
      level_d = level_q - 10'h001;
    end
    unique case (trg_q)
      IRF_TRG_IDLE: begin
        if (mode == IRF_MODE_TRIGGER) begin
          trg_d = IRF_TRG_ARMED;
        end
      end
      IRF_TRG_ARMED: begin
        if (mode != IRF_MODE_TRIGGER) begin
          trg_d = IRF_TRG_IDLE;
        end else if (trig_evt) begin
          trg_d = IRF_TRG_HOLD;
        end
      end
      IRF_TRG_HOLD: begin
        if (mode != IRF_MODE_TRIGGER) begin
          trg_d = IRF_TRG_IDLE;
        end
      end
      default: trg_d = IRF_TRG_IDLE;
    endcase
    // debug pointer reset holds pointers, level, trigger state and pop valid at zero
    if (ptr_rst) begin
      rptr_d = 9'h000;
      wptr_d = 9'h000;
      level_d = 10'h000;
      trg_d = IRF_TRG_IDLE;
      pop_valid_d = 1'b0;
    end
  end

  // ==========================================================
  // register file, status and pin b
  always_comb begin
    thresh = {fctrl_q[`IRF_B_THR_MSB], thrlo_q};
    wmark_hit = (level_q >= {1'b0, thresh});
    stat_rd = reg_rd_in && (reg_addr_in == `IRF_OFS_STAT);
    route_d = route_q;
    fctrl_d = fctrl_q;
    thrlo_d = thrlo_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `IRF_OFS_ROUTE: route_d = reg_wdata_in;
        `IRF_OFS_FCTRL: fctrl_d = reg_wdata_in & 8'hF9;
        `IRF_OFS_THRLO: thrlo_d = reg_wdata_in;
        `IRF_OFS_MASK: mask_d = reg_wdata_in[2:0];
        `IRF_OFS_STAT: begin
          stat_d[`IRF_S_OVRUN] = w1c(stat_q[`IRF_S_OVRUN], reg_wdata_in[`IRF_S_OVRUN]);
          stat_d[`IRF_S_TRIG] = w1c(stat_q[`IRF_S_TRIG], reg_wdata_in[`IRF_S_TRIG]);
        end
        default: ;
      endcase
    end
    // watermark clears on read of the status register
    if (stat_rd) begin
      stat_d[`IRF_S_WMARK] = 1'b0;
    end
    // hardware sets win over software clears
    if (wmark_hit) begin
      stat_d[`IRF_S_WMARK] = 1'b1;
    end
    if (overrun) begin
      stat_d[`IRF_S_OVRUN] = 1'b1;
    end
    if (trg_q == IRF_TRG_ARMED && trig_evt) begin
      stat_d[`IRF_S_TRIG] = 1'b1;
    end
    // read data, zero for unmapped offsets
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `IRF_OFS_ROUTE: rdata_d = route_q;
        `IRF_OFS_FCTRL: rdata_d = fctrl_q;
        `IRF_OFS_THRLO: rdata_d = thrlo_q;
        `IRF_OFS_STAT: rdata_d = {5'h00, stat_q};
        `IRF_OFS_MASK: rdata_d = {5'h00, mask_q};
        `IRF_OFS_LVLLO: rdata_d = level_q[7:0];
        `IRF_OFS_LVLHI: rdata_d = {4'h0, trg_q, level_q[9:8]};
        default: rdata_d = 8'h00;
      endcase
    end
    // routed sources onto pin b
    pin_d = (route_q[`IRF_B_NVM_COMPLETE_STATUS] & nvm_complete_status_in) |
      (route_q[`IRF_B_NVM_REQ] & nvm_request_status_in) |
      (route_q[`IRF_B_UV] & undervoltage_held_flag_in) |
      (route_q[`IRF_B_OVR] & overrange_held_flag_in) |
      (route_q[`IRF_B_PAR] & parity_fault_status_in) |
      (route_q[`IRF_B_TAP3] & tap_three_in) |
      (route_q[`IRF_B_TAP2] & tap_two_in) |
      (route_q[`IRF_B_TAP1] & tap_one_in);
    irq_d = |(stat_d & mask_d);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      route_q <= `IRF_RST_ROUTE;
      fctrl_q <= `IRF_RST_FCTRL;
      thrlo_q <= `IRF_RST_THRLO;
      stat_q <= `IRF_RST_STAT;
      mask_q <= `IRF_RST_MASK;
      rdata_q <= 8'h00;
      pin_q <= 1'b0;
      irq_q <= 1'b0;
      rptr_q <= 9'h000;
      wptr_q <= 9'h000;
      level_q <= 10'h000;
      trg_q <= IRF_TRG_IDLE;
      frame_sync_pin_q <= 1'b0;
      pop_valid_q <= 1'b0;
      pop_data_q <= 18'h00000;
    end else begin
      route_q <= route_d;
      fctrl_q <= fctrl_d;
      thrlo_q <= thrlo_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      pin_q <= pin_d;
      irq_q <= irq_d;
      rptr_q <= rptr_d;
      wptr_q <= wptr_d;
      level_q <= level_d;
      trg_q <= trg_d;
      frame_sync_pin_q <= frame_sync_pin_in;
      pop_valid_q <= pop_valid_d;
      pop_data_q <= pop_data_d;
    end
  end

  // sample storage, written at the write pointer
  always_ff @(posedge clk_in) begin
    if (push_ok) begin
      mem_q[wptr_q] <= wr_word;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_out = rdata_q;
  assign pop_valid_out = pop_valid_q;
  assign pop_data_out = pop_data_q;
  assign irq_pin_b_out = pin_q;
  assign irq_out = irq_q;

endmodule

// >>> irf_host.sv
`timescale 1ns/1ps
module irf_host (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // host controls
  input wire logic drain_in,
  input wire logic slow_in,
  // pop request
  output logic pop_out
);
  logic [1:0] gap_q;
  // pops every cycle while draining, or one in four when the host is slow
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gap_q <= 2'h0;
      pop_out <= 1'b0;
    end else begin
      gap_q <= gap_q + 2'h1;
      pop_out <= drain_in && (!slow_in || gap_q == 2'h0);
    end
  end
endmodule

// >>> irf_props.sv
`timescale 1ns/1ps
module irf_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // pin b sources
  input wire logic nvm_complete_status_in,
  input wire logic nvm_request_status_in,
  input wire logic undervoltage_held_flag_in,
  input wire logic overrange_held_flag_in,
  input wire logic parity_fault_status_in,
  input wire logic tap_three_in,
  input wire logic tap_two_in,
  input wire logic tap_one_in,
  // pops and interrupts
  input wire logic pop_in,
  input wire logic pop_valid_out,
  input wire logic irq_pin_b_out,
  input wire logic irq_out
);
  logic [7:0] route_q, fctrl_q, thr_q, src;
  logic mask_q;
  assign src = {nvm_complete_status_in, nvm_request_status_in, undervoltage_held_flag_in,
    overrange_held_flag_in, parity_fault_status_in, tap_three_in, tap_two_in, tap_one_in};
  // shadow copies of the routing, fifo control and threshold registers and mask bit 0
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      route_q <= 8'h80;
      fctrl_q <= 8'h00;
      thr_q <= 8'h00;
      mask_q <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h2E) route_q <= reg_wdata_in;
      if (reg_addr_in == 8'h30) fctrl_q <= reg_wdata_in & 8'hF9;
      if (reg_addr_in == 8'h31) thr_q <= reg_wdata_in;
      if (reg_addr_in == 8'h39) mask_q <= reg_wdata_in[0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_pin_b_route: assert property (1 |=> irq_pin_b_out == $past(|(route_q & src)))
    else $error("pin b differs from routed sources");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_route_read: assert property (reg_rd_in && reg_addr_in == 8'h2E |=> reg_rdata_out == $past(route_q))
    else $error("routing readback wrong");
  a_fctrl_read: assert property (reg_rd_in && reg_addr_in == 8'h30 |=> reg_rdata_out == $past(fctrl_q))
    else $error("fifo control readback wrong");
  a_thr_read: assert property (reg_rd_in && reg_addr_in == 8'h31 |=> reg_rdata_out == $past(thr_q))
    else $error("threshold readback wrong");
  a_ptr_hold: assert property (fctrl_q[7] |=> !pop_valid_out)
    else $error("pop served during pointer reset");
  a_pop_cause: assert property (pop_valid_out |-> $past(pop_in))
    else $error("pop valid without a pop");
  a_wmark_irq: assert property (thr_q == 8'h00 && !fctrl_q[0] && mask_q &&
    !(reg_wr_in && reg_addr_in == 8'h39) |=> irq_out)
    else $error("zero threshold watermark not flagged");
  c_pop: cover property (pop_valid_out);
  c_pin_b: cover property (irq_pin_b_out);
  c_irq_read: cover property (irq_out && reg_rd_in);
endmodule
bind irf_top irf_props irf_props_inst (.*);

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  import irf_pkg::*;
  logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, pop_in, pop_valid_out, irq_pin_b_out, irq_out;
  logic nvm_complete_status_in, nvm_request_status_in, undervoltage_held_flag_in;
  logic overrange_held_flag_in, parity_fault_status_in, tap_three_in, tap_two_in, tap_one_in;
  logic sample_valid_in, pulse_density_output_in, frame_sync_pin_in, activity_in, drain, slow;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, r, s, re;
  logic [15:0] sample_data_in;
  logic [1:0] sample_chan_in, m;
  logic rd_p = 1'b0;
  irf_word_t pop_data_out, dx;
  logic [7:0] rq[$];
  irf_word_t dq[$];
  int fail_count, checks_done;
  irf_top irf_top_inst (.*);
  irf_host irf_host_inst (.clk_in, .rst_n_in, .drain_in(drain), .slow_in(slow), .pop_out(pop_in));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ==========================================================
  // bus and stream tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic push(input logic keep, input logic tag);
    logic [15:0] d;
    logic [1:0] c;
    d = 16'($urandom);
    c = 2'($urandom);
    if (keep) dq.push_back({tag ? c : 2'b00, d});
    @(posedge clk_in);
    sample_valid_in <= 1'b1;
    sample_data_in <= d;
    sample_chan_in <= c;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
  endtask
  task automatic empty_out(input logic sl);
    @(posedge clk_in);
    drain <= 1'b1;
    slow <= sl;
    tick(24);
    drain <= 1'b0;
    tick(3);
  endtask
  task automatic trig_pulse(input logic ext);
    @(posedge clk_in);
    if (ext) frame_sync_pin_in <= 1'b1;
    else activity_in <= 1'b1;
    @(posedge clk_in);
    {frame_sync_pin_in, activity_in} <= 2'b00;
  endtask
  task automatic close_out;
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // result watcher: oldest note against each answer
  always @(negedge clk_in) begin
    if (rd_p) begin
      re = rq.pop_front();
      `CHK("reg_rdata", re, reg_rdata_out)
    end
    rd_p = reg_rd_in;
    if (pop_valid_out) begin
      dx = (dq.size() > 0) ? dq.pop_front() : 'x;
      `CHK("pop_data", dx, pop_data_out)
    end
  end
  // watchdog
  initial begin
    #1000000;
    fail_count++;
    close_out();
  end
  // ==========================================================
  // main sequence
  initial begin
    {reg_wr_in, reg_rd_in, sample_valid_in, pulse_density_output_in, drain, slow} = '0;
    {frame_sync_pin_in, activity_in, rst_n_in} = '0;
    {reg_addr_in, reg_wdata_in, sample_data_in, sample_chan_in} = '0;
    {nvm_complete_status_in, nvm_request_status_in, undervoltage_held_flag_in} = '0;
    {overrange_held_flag_in, parity_fault_status_in, tap_three_in, tap_two_in, tap_one_in} = '0;
    void'($urandom(89));
    tick(20);
    rst_n_in <= 1'b1;
    rd(8'h2E, 8'h80);
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h10, 8'h00);
    // each route alone, then random mixes
    for (int i = 0; i < 24; i++) begin
      r = (i < 8) ? (8'h01 << i) : 8'($urandom);
      s = 8'($urandom);
      wr(8'h2E, r);
      rd(8'h2E, r);
      @(posedge clk_in);
      {nvm_complete_status_in, nvm_request_status_in, undervoltage_held_flag_in,
        overrange_held_flag_in, parity_fault_status_in, tap_three_in, tap_two_in, tap_one_in} <= s;
      @(posedge clk_in);
      @(negedge clk_in);
      `CHK("irq_pin_b", |(r & s), irq_pin_b_out)
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'hF9);
    // stored samples vanish under pointer reset
    wr(8'h30, 8'h10);
    repeat (3) push(1'b0, 1'b0);
    wr(8'h30, 8'h90);
    wr(8'h30, 8'h10);
    empty_out(1'b0);
    // every mode with and without tags, then pulse density output
    for (int i = 0; i < 10; i++) begin
      m = (i > 7) ? 2'b01 : 2'(i);
      wr(8'h30, {1'b0, 1'(i >> 2), m, 4'h0});
      @(posedge clk_in);
      pulse_density_output_in <= (i > 7);
      tick(3);
      repeat (4) push(m != 2'b00 && i < 8, 1'(i >> 2));
      empty_out(1'(i));
    end
    @(posedge clk_in);
    pulse_density_output_in <= 1'b0;
    // watermark raise, mask and clear on read
    wr(8'h30, 8'h10);
    wr(8'h39, 8'h01);
    tick(2);
    @(negedge clk_in);
    `CHK("irq", 1'b1, irq_out)
    wr(8'h31, 8'h03);
    rd(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    tick(2);
    @(negedge clk_in);
    `CHK("irq", 1'b0, irq_out)
    repeat (3) push(1'b1, 1'b0);
    tick(2);
    @(negedge clk_in);
    `CHK("irq", 1'b1, irq_out)
    empty_out(1'b1);
    wr(8'h39, 8'h00);
    tick(2);
    @(negedge clk_in);
    `CHK("irq", 1'b0, irq_out)
    rd(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    // trigger capture: frame sync edge, internal activity, stream mode
    wr(8'h30, 8'h38);
    rd(8'h3B, 8'h04);
    trig_pulse(1'b0);
    rd(8'h3B, 8'h04);
    trig_pulse(1'b1);
    rd(8'h3B, 8'h0C);
    rd(8'h38, 8'h04);
    wr(8'h38, 8'h04);
    wr(8'h30, 8'h28);
    trig_pulse(1'b1);
    rd(8'h3B, 8'h00);
    rd(8'h38, 8'h00);
    wr(8'h30, 8'h30);
    rd(8'h3B, 8'h04);
    trig_pulse(1'b0);
    rd(8'h3B, 8'h0C);
    rd(8'h38, 8'h04);
    wr(8'h38, 8'h04);
    rd(8'h38, 8'h00);
    // fill to full in normal mode, one more sample overruns
    wr(8'h30, 8'h10);
    repeat (321) push(1'b0, 1'b0);
    rd(8'h3A, 8'h40);
    rd(8'h3B, 8'h01);
    wr(8'h31, 8'h41);
    wr(8'h30, 8'h11);
    rd(8'h38, 8'h03);
    rd(8'h38, 8'h02);
    wr(8'h31, 8'h40);
    rd(8'h38, 8'h03);
    wr(8'h38, 8'h02);
    rd(8'h38, 8'h01);
    wr(8'h30, 8'h90);
    rd(8'h3A, 8'h00);
    wr(8'h30, 8'h10);
    rd(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    // reset again mid-run: routing back to its default
    tick(2);
    rst_n_in <= 1'b0;
    tick(3);
    rst_n_in <= 1'b1;
    rd(8'h2E, 8'h80);
    @(negedge clk_in);
    `CHK("irq_pin_b", s[7], irq_pin_b_out)
    `CHK("irq", 1'b0, irq_out)
    tick(4);
    if (rq.size() + dq.size() != 0) fail_count++;
    close_out();
  end
endmodule
